/* File: logic/fhrf_regs.sv */
// Behaviour
// - Alternate mode: SB bit 4 is inverse of write-data copy latched on rising edge.
// - Alternate mode: SB bit 3 inverse latched read data, bit 2 inverse latched gate.
// - Alternate mode: SB bits 1 and 0 are drive D and C select levels.
// - Digital output register is write-only at offset 2, cleared by master reset.
// - Tape register holds only bits 1:0 unless three-mode is enabled.
// - Three-mode: tape bits 7:6 and 3:2 copy media and boot configuration bits.
// - Three-mode: tape bits 5:4 give drive type of last selected drive.
// - Tape select 00 means none, 01..11 drives 1..3; drive 0 never tape.
// - Data rate follows latest write to offset 4 or offset 7.
// - Rate register bit 7 is software reset, bit 6 is power-down.
// - Precomp code: 000 default, 001..110 steps of 41.67 ns (20.8 ns at fast tape rate), 111 off.
// - Rate codes 500K,300K,250K,1M; reduced current high for codes 00 and 11.
// - Fast tape rate only with rate 01 and extension bits 10.
// - Data port passes bytes; FIFO stays disabled after reset until configured.
// - Status zero termination: 01 abnormal, 10 invalid, 11 ready changed.
// - Status two flags address mark, cylinder, scan, CRC, control mark; bit 7 zero.
// - Basic mode input register read drives only bit 7, inverse disk change.
// - Extended input read: inverse change, ones, rate, low density flag.
// - Alternate input read: change level, ones, DMA enable, no-precomp, rate.
// - Config control is write-only, sets rate; alternate mode stores no-precomp bit.
// - Extended mode: SB bit 5 shows drive select bit 0.
//
// Decided for this implementation: the strobed register port.
`default_nettype none
module fhrf_regs (
    input  wire logic                      core_clk_i,
    input  wire logic                      rst_i,
    input  wire logic [2:0]                addr_i,
    input  wire logic [7:0]                wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic      [7:0]                rdata_o,
    output logic      [7:0]                rdata_en_n_o,
    input  wire fhrf_pkg::fhrf_mode_t      mode_i,
    input  wire logic                      three_mode_enable_i,
    input  wire logic [7:0]                drive_type_config_i,
    input  wire logic [3:0]                media_boot_config_i,
    input  wire logic                      rate_ext_hi_i,
    input  wire logic                      rate_ext_lo_i,
    input  wire logic                      write_data_out_i,
    input  wire logic                      write_gate_out_i,
    input  wire logic                      drive_d_select_n_i,
    input  wire logic                      drive_c_select_n_i,
    input  wire logic                      read_data_in_i,
    input  wire logic                      disk_change_in_n_i,
    input  wire fhrf_pkg::fhrf_seq_stat_t  seq_stat_i,
    input  wire logic [7:0]                result_byte_i,
    input  wire logic                      fifo_config_i,
    input  wire logic                      fifo_config_en_i,
    input  wire logic                      status_load_i,
    input  wire fhrf_pkg::fhrf_st0_info_t  st0_info_i,
    input  wire fhrf_pkg::fhrf_st2_flags_t st2_flags_i,
    output fhrf_pkg::fhrf_dout_t           dout_o,
    output logic      [1:0]                tape_sel_o,
    output logic      [1:0]                rate_code_o,
    output logic      [2:0]                precomp_code_o,
    output logic      [15:0]               precomp_delay_o,
    output logic                           power_down_o,
    output logic                           ctrl_reset_o,
    output logic                           reduced_write_current_n_o,
    output logic                           tape_2m_o,
    output logic                           fifo_enable_o,
    output logic                           cmd_wr_o,
    output logic      [7:0]                cmd_byte_o,
    output logic                           result_rd_o,
    output logic      [7:0]                result_status_zero_o,
    output logic      [7:0]                result_status_two_o
);
    typedef struct packed {
        fhrf_pkg::fhrf_dout_t dout;
        logic [1:0]  tsel;
        logic [1:0]  rate;
        logic [2:0]  pc;
        logic [15:0] pc_delay;
        logic        pdown;
        logic        no_precomp_flag;
        logic        fifo_on;
        logic        swrst;
        logic        wd_lat;
        logic        rd_lat;
        logic        we_lat;
        logic        wd_tog;
        logic        rd_tog;
        logic        wd_prev;
        logic        rd_prev;
        logic        we_prev;
        logic [7:0]  rdata;
        logic [7:0]  rdata_en_n;
        logic        cmd_wr;
        logic [7:0]  cmd_byte;
        logic        res_rd;
        logic [7:0]  st0;
        logic [7:0]  st2;
        logic        rwc_n;
        logic        tape2m;
    } fhrf_regs_st_t;

    fhrf_regs_st_t st_ff;
    fhrf_regs_st_t nxt_st;
    logic [1:0]    pin_sync;
    logic          rdata_pin;
    logic          dskchg_n;

    // High density rates are 500K and 1M.
    function automatic logic fhrf_high_dens(input logic [1:0] rate);
        fhrf_high_dens = (rate == fhrf_pkg::FHRF_RATE_500K) || (rate == fhrf_pkg::FHRF_RATE_1M);
    endfunction : fhrf_high_dens

    // Precompensation delay in 10 ps units; fast tape uses half steps.
    function automatic logic [15:0] fhrf_pc_delay(input logic [2:0] code,
                                                  input logic [1:0] rate,
                                                  input logic       fast);
        logic [15:0] step;
        step = fast ? fhrf_pkg::FHRF_PC_STEP_2M : fhrf_pkg::FHRF_PC_STEP;
        if (code == fhrf_pkg::FHRF_PC_OFF) begin
            fhrf_pc_delay = 16'h0000;
        end else if (code != fhrf_pkg::FHRF_PC_DEFAULT) begin
            fhrf_pc_delay = 16'((32'(code) * 32'(step)));
        end else if (fast) begin
            fhrf_pc_delay = fhrf_pkg::FHRF_PC_STEP_2M;
        end else if (rate == fhrf_pkg::FHRF_RATE_1M) begin
            fhrf_pc_delay = fhrf_pkg::FHRF_PC_STEP;
        end else begin
            fhrf_pc_delay = fhrf_pkg::FHRF_PC_DEF;
        end
    endfunction : fhrf_pc_delay

    // Read data and disk change come from the drive cable, unrelated to our clock.
    fhrf_sync2 #(
        .W (2)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    ({read_data_in_i, disk_change_in_n_i}),
        .sync_o     (pin_sync)
    );
    assign rdata_pin = pin_sync[1];
    assign dskchg_n  = pin_sync[0];

    // All register state advances here; reset is synchronous and loads constants.
    always_comb begin
        logic wr_dr;
        logic wr_cc;
        nxt_st            = st_ff;
        wr_dr             = wr_i && (addr_i == fhrf_pkg::FHRF_OFS_MSR_DR);
        wr_cc             = wr_i && (addr_i == fhrf_pkg::FHRF_OFS_DI_CC);
        nxt_st.cmd_wr     = 1'b0;
        nxt_st.res_rd     = 1'b0;
        nxt_st.swrst      = 1'b0;
        nxt_st.rdata      = 8'h00;
        nxt_st.rdata_en_n = fhrf_pkg::FHRF_UNDRIVEN;

        // Pin edge tracking; latches hold until reset, toggles flip per rising edge.
        nxt_st.wd_prev = write_data_out_i;
        nxt_st.rd_prev = rdata_pin;
        nxt_st.we_prev = write_gate_out_i;
        if (write_data_out_i && !st_ff.wd_prev) begin
            nxt_st.wd_lat = 1'b1;
            nxt_st.wd_tog = !st_ff.wd_tog;
        end
        if (rdata_pin && !st_ff.rd_prev) begin
            nxt_st.rd_lat = 1'b1;
            nxt_st.rd_tog = !st_ff.rd_tog;
        end
        if (write_gate_out_i && !st_ff.we_prev) begin
            nxt_st.we_lat = 1'b1;
        end

        // Register writes.
        if (wr_i && (addr_i == fhrf_pkg::FHRF_OFS_DOUT)) begin
            nxt_st.dout = wdata_i;
        end
        if (wr_i && (addr_i == fhrf_pkg::FHRF_OFS_TAPE)) begin
            nxt_st.tsel = wdata_i[1:0];
        end
        if (wr_dr) begin
            nxt_st.rate  = wdata_i[1:0];
            nxt_st.pc    = wdata_i[fhrf_pkg::FHRF_DR_PC_LSB +: 3];
            nxt_st.pdown = wdata_i[fhrf_pkg::FHRF_DR_PDOWN_BIT];
            nxt_st.swrst = wdata_i[fhrf_pkg::FHRF_DR_SWRST_BIT];
        end
        if (wr_cc) begin
            nxt_st.rate = wdata_i[1:0];
            if (mode_i == fhrf_pkg::FHRF_MODE_ALT) begin
                nxt_st.no_precomp_flag = wdata_i[fhrf_pkg::FHRF_CC_NO_PRECOMP_FLAG_BIT];
            end
        end

        // Data port: bytes pass straight to and from the sequencer.
        if (wr_i && (addr_i == fhrf_pkg::FHRF_OFS_DATA)) begin
            nxt_st.cmd_wr   = 1'b1;
            nxt_st.cmd_byte = wdata_i;
        end
        // A configure command rewrites the FIFO enable; software reset drops it.
        if (fifo_config_i) begin
            nxt_st.fifo_on = fifo_config_en_i;
        end
        if (nxt_st.swrst) begin
            nxt_st.fifo_on = 1'b0;
        end

        // Result status bytes are assembled when the sequencer ends a command.
        if (status_load_i) begin
            nxt_st.st0 = {st0_info_i.term, st0_info_i.seek_end, st0_info_i.equip_check,
                          1'b0, st0_info_i.head, st0_info_i.drive};
            nxt_st.st2 = {1'b0, st2_flags_i};
        end

        // Reads: data stands for exactly the cycle after the strobe.
        if (rd_i) begin
            nxt_st.rdata_en_n = 8'h00;
            if (addr_i == fhrf_pkg::FHRF_OFS_STAT_B) begin
                if (mode_i == fhrf_pkg::FHRF_MODE_ALT) begin
                    nxt_st.rdata = {1'b1, st_ff.dout.drive_sel != 2'h1, st_ff.dout.drive_sel != 2'h0,
                                    !st_ff.wd_lat,
                                    !st_ff.rd_lat, !st_ff.we_lat,
                                    drive_d_select_n_i, drive_c_select_n_i};
                end else begin
                    nxt_st.rdata = {2'b11, st_ff.dout.drive_sel[0],
                                    st_ff.wd_tog, st_ff.rd_tog, !write_gate_out_i,
                                    st_ff.dout.motor_en[1:0]};
                end
            end else if (addr_i == fhrf_pkg::FHRF_OFS_TAPE) begin
                if (three_mode_enable_i) begin
                    nxt_st.rdata = {media_boot_config_i[3:2],
                                    drive_type_config_i[2*st_ff.dout.drive_sel +: 2],
                                    media_boot_config_i[1:0], st_ff.tsel};
                end else begin
                    nxt_st.rdata = {6'h00, st_ff.tsel};
                end
            end else if (addr_i == fhrf_pkg::FHRF_OFS_MSR_DR) begin
                nxt_st.rdata = seq_stat_i;
            end else if (addr_i == fhrf_pkg::FHRF_OFS_DATA) begin
                nxt_st.rdata  = result_byte_i;
                nxt_st.res_rd = 1'b1;
            end else if (addr_i == fhrf_pkg::FHRF_OFS_DI_CC) begin
                if (mode_i == fhrf_pkg::FHRF_MODE_AT) begin
                    nxt_st.rdata      = {!dskchg_n, 7'h00};
                    nxt_st.rdata_en_n = 8'h7F;
                end else if (mode_i == fhrf_pkg::FHRF_MODE_EXT) begin
                    nxt_st.rdata = {!dskchg_n, 4'hF, st_ff.rate,
                                    !fhrf_high_dens(st_ff.rate)};
                end else begin
                    nxt_st.rdata = {dskchg_n, 3'h7, st_ff.dout.dma_gate_enable,
                                    st_ff.no_precomp_flag, st_ff.rate};
                end
            end
        end

        // Derived outputs follow the freshly written rate and precomp fields.
        nxt_st.rwc_n    = fhrf_high_dens(nxt_st.rate);
        nxt_st.tape2m   = (nxt_st.rate == fhrf_pkg::FHRF_RATE_300K) &&
                          ({rate_ext_hi_i, rate_ext_lo_i} == fhrf_pkg::FHRF_EXT_2M);
        nxt_st.pc_delay = fhrf_pc_delay(nxt_st.pc, nxt_st.rate, nxt_st.tape2m);

        if (rst_i) begin
            nxt_st            = '0;
            nxt_st.dout       = fhrf_pkg::FHRF_DOUT_RST;
            nxt_st.rate       = fhrf_pkg::FHRF_RATE_RST;
            nxt_st.rdata_en_n = fhrf_pkg::FHRF_UNDRIVEN;
            nxt_st.rwc_n      = 1'b1;
            nxt_st.pc_delay   = fhrf_pkg::FHRF_PC_DEF;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_ff <= nxt_st;
    end

    // Every output is a state bit; the controller reset pulse comes from the software reset bit only.
    assign dout_o                    = st_ff.dout;
    assign tape_sel_o                = st_ff.tsel;
    assign rate_code_o               = st_ff.rate;
    assign precomp_code_o            = st_ff.pc;
    assign precomp_delay_o           = st_ff.pc_delay;
    assign power_down_o              = st_ff.pdown;
    assign reduced_write_current_n_o = st_ff.rwc_n;
    assign tape_2m_o                 = st_ff.tape2m;
    assign fifo_enable_o             = st_ff.fifo_on;
    assign cmd_wr_o                  = st_ff.cmd_wr;
    assign cmd_byte_o                = st_ff.cmd_byte;
    assign result_rd_o               = st_ff.res_rd;
    assign result_status_zero_o      = st_ff.st0;
    assign result_status_two_o       = st_ff.st2;
    assign rdata_o                   = st_ff.rdata;
    assign rdata_en_n_o              = st_ff.rdata_en_n;
    assign ctrl_reset_o              = st_ff.swrst;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_alt_sb_read;
        rd_i && (addr_i == fhrf_pkg::FHRF_OFS_STAT_B) && (mode_i == fhrf_pkg::FHRF_MODE_ALT);
    endsequence
    sequence s_wd_rise_then_read;
        $rose(write_data_out_i) ##1 s_alt_sb_read;
    endsequence

    a_dout_reset_clear: assert property ($fell(rst_i) |-> (dout_o == 8'h00) && !fifo_enable_o)
        else $error("output register or FIFO enable not clear after reset");
    a_wd_latch_read: assert property (s_wd_rise_then_read |=> !rdata_o[4])
        else $error("write data latch not shown inverted");
    a_sel_pins_read: assert property (s_alt_sb_read |=>
        rdata_o[1:0] == $past({drive_d_select_n_i, drive_c_select_n_i}))
        else $error("drive select levels wrong");
    a_rate_last_write: assert property (wr_i && (addr_i == fhrf_pkg::FHRF_OFS_DI_CC ||
        addr_i == fhrf_pkg::FHRF_OFS_MSR_DR) |=> rate_code_o == $past(wdata_i[1:0]))
        else $error("rate does not follow latest write");
    a_rwc_by_rate: assert property (reduced_write_current_n_o ==
        (rate_code_o == 2'h0 || rate_code_o == 2'h3))
        else $error("reduced write current wrong for rate");
    a_tape_fast_only: assert property (tape_2m_o |-> rate_code_o == 2'h1)
        else $error("fast tape rate without rate code 01");
    a_di_basic_read: assert property (rd_i && addr_i == fhrf_pkg::FHRF_OFS_DI_CC &&
        mode_i == fhrf_pkg::FHRF_MODE_AT |=> rdata_en_n_o == 8'h7F ##1 (rdata_en_n_o == 8'hFF || $past(rd_i)))
        else $error("basic input read drives wrong lanes");
    a_di_ext_ones: assert property (rd_i && addr_i == fhrf_pkg::FHRF_OFS_DI_CC &&
        mode_i == fhrf_pkg::FHRF_MODE_EXT |=> rdata_o[6:3] == 4'hF)
        else $error("extended input read ones missing");
    a_st2_unused_zero: assert property (!result_status_two_o[7])
        else $error("status two unused bit set");
    a_tape_media_copy: assert property (rd_i && addr_i == fhrf_pkg::FHRF_OFS_TAPE && three_mode_enable_i
        |=> rdata_o[7:6] == $past(media_boot_config_i[3:2]))
        else $error("media bits not copied");
endmodule : fhrf_regs
`default_nettype wire

/* File: logic/fhrf_pkg.sv */
`default_nettype none
package fhrf_pkg;
    // Register offsets on the three-bit host address.
    localparam logic [2:0] FHRF_OFS_STAT_A = 3'h0;
    localparam logic [2:0] FHRF_OFS_STAT_B = 3'h1;
    localparam logic [2:0] FHRF_OFS_DOUT   = 3'h2;
    localparam logic [2:0] FHRF_OFS_TAPE   = 3'h3;
    localparam logic [2:0] FHRF_OFS_MSR_DR = 3'h4;
    localparam logic [2:0] FHRF_OFS_DATA   = 3'h5;
    localparam logic [2:0] FHRF_OFS_DI_CC  = 3'h7;

    // Field positions of the data rate and configuration control writes.
    localparam int FHRF_DR_SWRST_BIT  = 7;
    localparam int FHRF_DR_PDOWN_BIT  = 6;
    localparam int FHRF_DR_PC_LSB     = 2;
    localparam int FHRF_CC_NO_PRECOMP_FLAG_BIT = 2;

    // Reset values.
    localparam logic [7:0] FHRF_DOUT_RST = 8'h00;
    localparam logic [1:0] FHRF_RATE_RST = 2'h0;
    localparam logic [7:0] FHRF_UNDRIVEN = 8'hFF;

    // Rate codes and extension code for the fast tape rate.
    localparam logic [1:0] FHRF_RATE_500K = 2'h0;
    localparam logic [1:0] FHRF_RATE_300K = 2'h1;
    localparam logic [1:0] FHRF_RATE_250K = 2'h2;
    localparam logic [1:0] FHRF_RATE_1M   = 2'h3;
    localparam logic [1:0] FHRF_EXT_2M    = 2'h2;

    // Precompensation delays in units of 10 ps.
    localparam logic [15:0] FHRF_PC_STEP    = 16'h1047; // 41.67 ns.
    localparam logic [15:0] FHRF_PC_STEP_2M = 16'h0820; // 20.8 ns.
    localparam logic [15:0] FHRF_PC_DEF     = 16'h30D4; // 125 ns.
    localparam logic [2:0]  FHRF_PC_DEFAULT = 3'h0;
    localparam logic [2:0]  FHRF_PC_OFF     = 3'h7;

    // Register compatibility modes; Gray order along the usual path.
    typedef enum logic [1:0] {
        FHRF_MODE_AT  = 2'b00,
        FHRF_MODE_EXT = 2'b01,
        FHRF_MODE_ALT = 2'b11
    } fhrf_mode_t;

    // Termination code of result status byte zero.
    typedef enum logic [1:0] {
        FHRF_TERM_NORMAL   = 2'b00,
        FHRF_TERM_ABNORMAL = 2'b01,
        FHRF_TERM_INVALID  = 2'b10,
        FHRF_TERM_READY    = 2'b11
    } fhrf_term_t;

    // Digital output register layout.
    typedef struct packed {
        logic [3:0] motor_en;
        logic       dma_gate_enable;
        logic       ctrl_run_n;
        logic [1:0] drive_sel;
    } fhrf_dout_t;

    // Sequencer state shown in the main status register.
    typedef struct packed {
        logic       port_ready;
        logic       to_host;
        logic       exec_phase;
        logic       busy;
        logic [3:0] seek_busy;
    } fhrf_seq_stat_t;

    // Result status byte zero sources.
    typedef struct packed {
        fhrf_term_t term;
        logic       seek_end;
        logic       equip_check;
        logic       head;
        logic [1:0] drive;
    } fhrf_st0_info_t;

    // Result status byte two flags, bit 6 down to bit 0.
    typedef struct packed {
        logic control_mark_flag;
        logic data_crc_error;
        logic wrong_cylinder_flag;
        logic scan_hit;
        logic scan_unmet_flag;
        logic bad_cylinder_flag;
        logic missing_data_mark;
    } fhrf_st2_flags_t;
endpackage : fhrf_pkg
`default_nettype wire

/* File: logic/fhrf_sync2.sv */
`default_nettype none
module fhrf_sync2 #(
    parameter int W = 2
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } fhrf_sync_st_t;

    fhrf_sync_st_t st_ff;
    fhrf_sync_st_t nxt_st;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_st.meta   = async_i;
        nxt_st.stable = st_ff.meta;
        if (rst_i) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_ff <= nxt_st;
    end

    assign sync_o = st_ff.stable;
endmodule : fhrf_sync2
`default_nettype wire

/* File: dv/fhrf_drive_model.sv */
`default_nettype none
module fhrf_drive_model (
    input  wire logic core_clk_i,
    input  wire logic motor_on_i,
    input  wire logic change_i,
    output logic      read_data_in_o,
    output logic      disk_change_in_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // A spinning disk yields flux pulses; a stopped one idles high so no stale edge is seen.
    logic flux = 1'b1;
    always @(posedge core_clk_i) begin
        flux <= motor_on_i ? ~flux : 1'b1;
    end
    assign read_data_in_o = flux;
    // Disk change is signalled active low once media has been swapped.
    assign disk_change_in_n_o = ~change_i;
endmodule : fhrf_drive_model
`default_nettype wire

/* File: dv/floppy_host_register_file_test.sv */
`default_nettype none
module floppy_host_register_file_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wr = 0, rd = 0, tme = 0, ehi = 0, elo = 0, wdo = 0, wgo = 0, dsd = 1, dsc = 1;
    logic fcfg = 0, fen = 0, sload = 0, chg = 1, rdi, dcn, pdn, creset, rwcn, t2m, fifoen, cwr, rrd;
    logic [2:0] addr = 0, pcode;
    logic [7:0] wdata = 0, dtc = 8'hE4, rbyte = 8'h5A, rdata, rden, s0, s2, cbyte;
    logic [3:0] mbc = 4'hB;
    logic [1:0] tsel, rate;
    logic [15:0] pdel;
    fhrf_pkg::fhrf_mode_t mode = fhrf_pkg::FHRF_MODE_AT;
    fhrf_pkg::fhrf_seq_stat_t seq = 8'h90;
    fhrf_pkg::fhrf_st0_info_t st0 = 7'h00;
    fhrf_pkg::fhrf_st2_flags_t st2 = 7'h7F;
    fhrf_pkg::fhrf_dout_t dout;
    int bad_count = 0, n_compared = 0;
    always #2 clk = ~clk;
    fhrf_drive_model i_fhrf_drive_model (.core_clk_i(clk), .motor_on_i(|dout.motor_en), .change_i(chg),
        .read_data_in_o(rdi), .disk_change_in_n_o(dcn));
    fhrf_regs i_fhrf_regs (.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .rdata_en_n_o(rden), .mode_i(mode), .three_mode_enable_i(tme),
        .drive_type_config_i(dtc), .media_boot_config_i(mbc), .rate_ext_hi_i(ehi), .rate_ext_lo_i(elo),
        .write_data_out_i(wdo), .write_gate_out_i(wgo), .drive_d_select_n_i(dsd), .drive_c_select_n_i(dsc),
        .read_data_in_i(rdi), .disk_change_in_n_i(dcn), .seq_stat_i(seq), .result_byte_i(rbyte),
        .fifo_config_i(fcfg), .fifo_config_en_i(fen), .status_load_i(sload), .st0_info_i(st0),
        .st2_flags_i(st2), .dout_o(dout), .tape_sel_o(tsel), .rate_code_o(rate), .precomp_code_o(pcode),
        .precomp_delay_o(pdel), .power_down_o(pdn), .ctrl_reset_o(creset), .reduced_write_current_n_o(rwcn),
        .tape_2m_o(t2m), .fifo_enable_o(fifoen), .cmd_wr_o(cwr), .cmd_byte_o(cbyte), .result_rd_o(rrd),
        .result_status_zero_o(s0), .result_status_two_o(s2));
    // Every comparison funnels through here so counts and reports stay consistent.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One-cycle write strobe; effects are checked after the sampling edge has landed.
    task automatic wrb(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask : wrb
    // Read data stand only in the cycle after the strobe, so it is sampled right there.
    task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata & m, e);
    endtask : rdc
    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #20000 bad_count++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1 chk({dout, 7'h00, rwcn}, 16'h0001);
        chk(pdel, 16'h30D4);
        chk(fifoen, 1'b0);
        wrb(3'h2, 8'h2D);
        chk(dout, 8'h2D);
        for (int i = 0; i < 4; i++) begin
            wrb(3'h4, 8'(i));
            chk({rate, rwcn}, {2'(i), 1'(i == 0 || i == 3)});
        end
        wrb(3'h4, 8'h05);
        chk({pcode, pdel}, {3'h1, 16'h1047});
        wrb(3'h4, 8'h1D);
        chk(pdel, 16'h0000);
        ehi = 1'b1;
        wrb(3'h4, 8'h01);
        chk(t2m, 1'b1);
        wrb(3'h7, 8'h02);
        chk({rate, t2m}, 3'b100);
        @(posedge clk) begin fcfg <= 1'b1; fen <= 1'b1; end
        @(posedge clk) fcfg <= 1'b0;
        #1 chk(fifoen, 1'b1);
        wrb(3'h4, 8'hC2);
        chk({creset, pdn, fifoen}, 3'b110);
        repeat (4) @(posedge clk);
        rdc(3'h7, 8'h80, 8'h80);
        chk(rden, 8'h7F);
        mode = fhrf_pkg::FHRF_MODE_EXT;
        rdc(3'h7, 8'hFF, 8'hFD);
        rdc(3'h1, 8'h20, 8'h20);
        mode = fhrf_pkg::FHRF_MODE_ALT;
        wrb(3'h7, 8'h06);
        rdc(3'h7, 8'hFF, 8'h7E);
        dsd = 1'b0;
        rdc(3'h1, 8'h13, 8'h11);
        wdo = 1'b1;
        wgo = 1'b1;
        rdc(3'h1, 8'h14, 8'h00);
        wrb(3'h3, 8'h02);
        chk(tsel, 2'h2);
        tme = 1'b1;
        rdc(3'h3, 8'hFF, 8'h9E);
        for (int t = 0; t < 4; t++) begin
            st0.term = fhrf_pkg::fhrf_term_t'(t);
            @(posedge clk) sload <= 1'b1;
            @(posedge clk) sload <= 1'b0;
            #1 chk({s0[7:6], s2}, {2'(t), 8'h7F});
        end
        wrb(3'h5, 8'hA5);
        chk({cwr, cbyte}, 9'h1A5);
        rdc(3'h5, 8'hFF, 8'h5A);
        chk(rrd, 1'b1);
        rdc(3'h4, 8'hFF, 8'h90);
        final_report();
    end
endmodule : floppy_host_register_file_test
`default_nettype wire
